// *** shared/pdc_pkg.sv ***
// Constants, types and register map for the phase detector configuration block
package pdc_pkg;
	localparam int PH_W = 24;
	localparam int FRAC_W = 10;
	localparam int SPAN_W = 13;
	localparam int FINE_SHIFT = 7;
	localparam int ADDR_W = 12;
	localparam int EVT_W = 3;
	typedef logic signed [PH_W-1:0] pdc_phase_t;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_GAIN2 = 8'h6C;
	localparam logic [7:0] IDX_GAIN1 = 8'h6D;
	localparam logic [7:0] IDX_OFS_LO = 8'h70;
	localparam logic [7:0] IDX_OFS_HI = 8'h71;
	localparam logic [7:0] IDX_BIAS = 8'h72;
	localparam logic [7:0] IDX_FINE = 8'h73;
	localparam logic [7:0] IDX_COARSE = 8'h74;
	localparam logic [7:0] IDX_STATUS = 8'h90;
	localparam logic [7:0] IDX_MASK = 8'h91;
	localparam logic [7:0] IDX_STATE = 8'h92;
	localparam logic [7:0] RST_GAIN = 8'hC2;
	localparam logic [7:0] RST_OFS_LO = 8'h00;
	localparam logic [7:0] RST_OFS_HI = 8'h00;
	localparam logic [7:0] RST_BIAS = 8'h00;
	localparam logic [7:0] RST_FINE = 8'hA2;
	localparam logic [7:0] RST_COARSE = 8'h85;
	localparam logic [EVT_W-1:0] RST_EVT = 3'h0;
	// Field positions
	localparam int B_AUTO = 7;
	localparam int B_FINE_EN = 7;
	localparam int B_INACT = 6;
	localparam int B_COARSE_EN = 7;
	localparam int B_WIDE = 6;
	localparam int B_MULTI = 5;
	localparam int BIAS_W = 6;
	// Event bits of status and mask
	localparam int EV_FINE = 0;
	localparam int EV_COARSE = 1;
	localparam int EV_INACT = 2;
	localparam logic [3:0] SPAN_SAT_CODE = 4'hC;
	localparam logic [SPAN_W-1:0] SPAN_MAX = 13'h1FFF;
	localparam pdc_phase_t ONE_UI = 24'h000400;
endpackage

// *** shared/pdc_irq_if.sv ***
// Event, clear and mask signals between the core and its interrupt unit
`timescale 1ns/1ps
interface pdc_irq_if;
	import pdc_pkg::*;
	logic [EVT_W-1:0] evt;
	logic [EVT_W-1:0] clr;
	logic [EVT_W-1:0] mask;
	logic [EVT_W-1:0] status;
	logic irq;
	modport core (output evt, output clr, output mask, input status, input irq);
	modport unit (input evt, input clr, input mask, output status, output irq);
endinterface

// *** hdl/pdc_span.sv ***
// Coarse phase span decoder: limit code to tracking range in UI
`timescale 1ns/1ps
module pdc_span (
	input wire logic [3:0] code,
	output logic [pdc_pkg::SPAN_W-1:0] span
);
	import pdc_pkg::*;
	wire sat_w = (code >= SPAN_SAT_CODE);
	wire [SPAN_W-1:0] pow_w = SPAN_W'(13'h0002 << code);
	assign span = sat_w ? SPAN_MAX : SPAN_W'(pow_w - 13'h0001);
endmodule

// *** hdl/pdc_irq.sv ***
// Sticky event status with write-one-to-clear and masked level interrupt
`timescale 1ns/1ps
module pdc_irq (
	input wire logic pclk,
	input wire logic presetn,
	pdc_irq_if.unit bus
);
	import pdc_pkg::*;
	logic [EVT_W-1:0] status_r;
	logic irq_r;
	// Set placed after clear so a same-cycle event is never lost
	wire [EVT_W-1:0] status_nxt = (status_r & ~bus.clr) | bus.evt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= RST_EVT;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r <= |(status_nxt & bus.mask);
		end
	end
	assign bus.status = status_r;
	assign bus.irq = irq_r;
	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|bus.evt) |=> ((status_r & $past(bus.evt)) == $past(bus.evt)))
		else $error("event lost against clear");
endmodule

// *** hdl/pdc_top.sv ***
// Phase detector configuration registers, limiter and loss detection
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module pdc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pdc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pdc_pkg::pdc_phase_t phase_meas,
	input wire logic no_activity,
	output pdc_pkg::pdc_phase_t loop_phase,
	output pdc_pkg::pdc_phase_t tracked_phase,
	output logic fine_loss,
	output logic coarse_loss,
	output logic phase_loss,
	output logic wide_detector_on,
	output logic multi_cycle_response_enable,
	output logic [15:0] phase_offset,
	output logic [pdc_pkg::BIAS_W-1:0] buildout_bias_value,
	output logic loop1_auto_gain_enable,
	output logic [2:0] loop1_analog_gain_code,
	output logic [2:0] loop1_digital_gain_code,
	output logic loop2_auto_gain_enable,
	output logic [2:0] loop2_analog_gain_code,
	output logic [2:0] loop2_digital_gain_code,
	output logic irq
);
	import pdc_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [7:0] loop2_detector_gain_cfg_r;
	logic [7:0] loop1_detector_gain_cfg_r;
	logic [7:0] phase_shift_low_byte_r;
	logic [7:0] phase_shift_high_byte_r;
	logic [7:0] buildout_bias_cfg_r;
	logic [7:0] fine_loss_window_cfg_r;
	logic [7:0] coarse_loss_window_cfg_r;
	logic [EVT_W-1:0] mask_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_nxt;
	logic pready_r;
	logic pslverr_r;
	pdc_phase_t loop_phase_r;
	pdc_phase_t tracked_r;
	logic fine_loss_r;
	logic coarse_loss_r;
	logic inact_loss_r;
	logic phase_loss_r;
	logic [SPAN_W-1:0] span_w;
	pdc_irq_if irq_bus ();

	function automatic pdc_phase_t clamp(input pdc_phase_t v, input pdc_phase_t lim);
		if (v > lim)
			clamp = lim;
		else if (v < -lim)
			clamp = -lim;
		else
			clamp = v;
	endfunction

	// APB decode
	wire [7:0] idx_w = paddr[9:2];
	wire aligned_w = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == 2'b00);
	wire setup_w = psel && !penable;
	wire wr_w = psel && penable && pready_r && pwrite && aligned_w;
	wire wr_gain2 = wr_w && (idx_w == IDX_GAIN2);
	wire wr_gain1 = wr_w && (idx_w == IDX_GAIN1);
	wire wr_ofs_lo = wr_w && (idx_w == IDX_OFS_LO);
	wire wr_ofs_hi = wr_w && (idx_w == IDX_OFS_HI);
	wire wr_bias = wr_w && (idx_w == IDX_BIAS);
	wire wr_fine = wr_w && (idx_w == IDX_FINE);
	wire wr_coarse = wr_w && (idx_w == IDX_COARSE);
	wire wr_status = wr_w && (idx_w == IDX_STATUS);
	wire wr_mask = wr_w && (idx_w == IDX_MASK);
	logic hit_w;

	always_comb begin
		hit_w = aligned_w;
		rd_nxt = 32'h0000_0000;
		if (idx_w == IDX_GAIN2) begin
			rd_nxt[7:0] = loop2_detector_gain_cfg_r;
		end else if (idx_w == IDX_GAIN1) begin
			rd_nxt[7:0] = loop1_detector_gain_cfg_r;
		end else if (idx_w == IDX_OFS_LO) begin
			rd_nxt[7:0] = phase_shift_low_byte_r;
		end else if (idx_w == IDX_OFS_HI) begin
			rd_nxt[7:0] = phase_shift_high_byte_r;
		end else if (idx_w == IDX_BIAS) begin
			rd_nxt[7:0] = buildout_bias_cfg_r;
		end else if (idx_w == IDX_FINE) begin
			rd_nxt[7:0] = fine_loss_window_cfg_r;
		end else if (idx_w == IDX_COARSE) begin
			rd_nxt[7:0] = coarse_loss_window_cfg_r;
		end else if (idx_w == IDX_STATUS) begin
			rd_nxt[EVT_W-1:0] = irq_bus.status;
		end else if (idx_w == IDX_MASK) begin
			rd_nxt[EVT_W-1:0] = mask_r;
		end else if (idx_w == IDX_STATE) begin
			rd_nxt[4:0] = {wide_detector_on, inact_loss_r, coarse_loss_r, fine_loss_r,
				phase_loss};
		end else begin
			hit_w = 1'b0;
		end
		if (!aligned_w) begin
			rd_nxt = 32'h0000_0000;
		end
	end

	// One wait-free access phase: answer prepared during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= setup_w;
			pslverr_r <= setup_w && !hit_w;
			prdata_r <= (setup_w && !pwrite) ? rd_nxt : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop2_detector_gain_cfg_r <= RST_GAIN;
			loop1_detector_gain_cfg_r <= RST_GAIN;
			phase_shift_low_byte_r <= RST_OFS_LO;
			phase_shift_high_byte_r <= RST_OFS_HI;
			buildout_bias_cfg_r <= RST_BIAS;
			fine_loss_window_cfg_r <= RST_FINE;
			coarse_loss_window_cfg_r <= RST_COARSE;
			mask_r <= RST_EVT;
		end else begin
			if (wr_gain2) loop2_detector_gain_cfg_r <= pwdata[7:0];
			if (wr_gain1) loop1_detector_gain_cfg_r <= pwdata[7:0];
			if (wr_ofs_lo) phase_shift_low_byte_r <= pwdata[7:0];
			if (wr_ofs_hi) phase_shift_high_byte_r <= pwdata[7:0];
			if (wr_bias) buildout_bias_cfg_r <= pwdata[7:0];
			if (wr_fine) fine_loss_window_cfg_r <= pwdata[7:0];
			if (wr_coarse) coarse_loss_window_cfg_r <= pwdata[7:0];
			if (wr_mask) mask_r <= pwdata[EVT_W-1:0];
		end
	end

	// Field views
	wire fine_en_w = fine_loss_window_cfg_r[B_FINE_EN];
	wire inact_en_w = fine_loss_window_cfg_r[B_INACT];
	wire [2:0] fine_code_w = fine_loss_window_cfg_r[2:0];
	wire coarse_en_w = coarse_loss_window_cfg_r[B_COARSE_EN];
	wire wide_w = coarse_loss_window_cfg_r[B_WIDE];
	wire multi_w = coarse_loss_window_cfg_r[B_MULTI];
	wire [3:0] coarse_code_w = coarse_loss_window_cfg_r[3:0];

	// Shared field: detector span and coarse loss limit
	pdc_span u_span (
		.code(coarse_code_w),
		.span(span_w)
	);

	wire pdc_phase_t span_lim_w = {1'b0, span_w, {FRAC_W{1'b0}}};
	wire pdc_phase_t abs_meas_w = phase_meas[PH_W-1] ? -phase_meas : phase_meas;
	wire [SPAN_W-1:0] abs_ui_w = abs_meas_w[PH_W-2:FRAC_W];
	// Window widens one step per code; code 2 sits near 135 degrees
	wire pdc_phase_t fine_win_w = {13'h0000, {1'b0, fine_code_w} + 4'h1,
		{FINE_SHIFT{1'b0}}};

	// Coarse result used only with the wide detector active as well
	wire use_coarse_w = multi_w && wide_w;
	// Unscaled full measurement keeps dynamics equal to divided locking
	wire pdc_phase_t loop_nxt = use_coarse_w ? clamp(phase_meas, span_lim_w)
		: clamp(phase_meas, ONE_UI);
	// Wide detector keeps the multi-UI position even when the loop is limited
	wire pdc_phase_t track_nxt = wide_w ? clamp(phase_meas, span_lim_w)
		: clamp(phase_meas, ONE_UI);
	wire fine_nxt = fine_en_w && (abs_meas_w > fine_win_w);
	wire coarse_nxt = coarse_en_w && (abs_ui_w > span_w);
	wire inact_nxt = inact_en_w && no_activity;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_phase_r <= '0;
			tracked_r <= '0;
			fine_loss_r <= 1'b0;
			coarse_loss_r <= 1'b0;
			inact_loss_r <= 1'b0;
			phase_loss_r <= 1'b0;
		end else begin
			loop_phase_r <= loop_nxt;
			tracked_r <= track_nxt;
			fine_loss_r <= fine_nxt;
			coarse_loss_r <= coarse_nxt;
			inact_loss_r <= inact_nxt;
			phase_loss_r <= fine_nxt || coarse_nxt || inact_nxt;
		end
	end

	assign irq_bus.evt[EV_FINE] = fine_nxt && !fine_loss_r;
	assign irq_bus.evt[EV_COARSE] = coarse_nxt && !coarse_loss_r;
	assign irq_bus.evt[EV_INACT] = inact_nxt && !inact_loss_r;
	assign irq_bus.clr = wr_status ? pwdata[EVT_W-1:0] : RST_EVT;
	assign irq_bus.mask = mask_r;

	pdc_irq u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.bus(irq_bus)
	);

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign loop_phase = loop_phase_r;
	assign tracked_phase = tracked_r;
	assign fine_loss = fine_loss_r;
	assign coarse_loss = coarse_loss_r;
	// Own flop for the OR, so the pin leaves a register like the others
	assign phase_loss = phase_loss_r;
	assign wide_detector_on = coarse_loss_window_cfg_r[B_WIDE];
	assign multi_cycle_response_enable = coarse_loss_window_cfg_r[B_MULTI];
	assign phase_offset = {phase_shift_high_byte_r, phase_shift_low_byte_r};
	assign buildout_bias_value = buildout_bias_cfg_r[BIAS_W-1:0];
	assign loop1_auto_gain_enable = loop1_detector_gain_cfg_r[B_AUTO];
	assign loop1_analog_gain_code = loop1_detector_gain_cfg_r[6:4];
	assign loop1_digital_gain_code = loop1_detector_gain_cfg_r[2:0];
	assign loop2_auto_gain_enable = loop2_detector_gain_cfg_r[B_AUTO];
	assign loop2_analog_gain_code = loop2_detector_gain_cfg_r[6:4];
	assign loop2_digital_gain_code = loop2_detector_gain_cfg_r[2:0];
	assign irq = irq_bus.irq;

	// Bus, interrupt and phase path checks
	wide_write_a: assert property (
		wr_coarse |=> wide_detector_on == $past(pwdata[B_WIDE]))
		else $error("wide enable not taken from write");
	multi_write_a: assert property (
		wr_coarse |=> multi_cycle_response_enable == $past(pwdata[B_MULTI]))
		else $error("multi cycle enable not taken from write");
	wide_track_a: assert property (
		wide_w && (phase_meas > span_lim_w) |=> tracked_phase == $past(span_lim_w))
		else $error("wide detector span not applied");
	loop_sat_a: assert property (
		!use_coarse_w |=> (loop_phase <= ONE_UI) && (loop_phase >= -ONE_UI))
		else $error("loop phase beyond one UI");
	multi_full_a: assert property (
		use_coarse_w && (phase_meas > ONE_UI) && (phase_meas <= span_lim_w)
		|=> loop_phase == $past(phase_meas))
		else $error("coarse result not passed to loop");
	fine_off_a: assert property (
		!fine_en_w |=> !fine_loss)
		else $error("fine loss while disabled");
	loss_or_a: assert property (
		phase_loss == (fine_loss || coarse_loss || inact_loss_r))
		else $error("phase loss not the sum of its sources");
	inact_loss_a: assert property (
		inact_en_w && no_activity |=> phase_loss)
		else $error("inactivity loss missed");
	fine_on_a: assert property (
		fine_en_w && (abs_meas_w > fine_win_w) |=> fine_loss)
		else $error("fine loss missed");
	coarse_on_a: assert property (
		coarse_en_w && (abs_ui_w > span_w) |=> coarse_loss ##0 phase_loss)
		else $error("coarse loss missed");
	coarse_off_a: assert property (
		!coarse_en_w |=> !coarse_loss)
		else $error("coarse loss while disabled");
	span_sat_a: assert property (
		(coarse_code_w >= SPAN_SAT_CODE) |-> span_w == SPAN_MAX)
		else $error("coarse span not saturated");
	reset_def_a: assert property (
		$past(presetn) == 1'b0 |-> (fine_loss_window_cfg_r == RST_FINE)
		&& (coarse_loss_window_cfg_r == RST_COARSE))
		else $error("defaults not loaded");
	offset_pair_a: assert property (
		wr_ofs_hi |=> phase_offset[15:8] == $past(pwdata[7:0])
		##1 $stable(phase_offset)[*2] or wr_w)
		else $error("phase offset high byte lost");
	offset_low_a: assert property (
		wr_ofs_lo |=> phase_offset[7:0] == $past(pwdata[7:0]))
		else $error("phase offset low byte lost");
	apb_answer_a: assert property (
		setup_w |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready held beyond one cycle");
	unmapped_err_a: assert property (
		setup_w && !hit_w |=> pslverr && (prdata == 32'h0000_0000))
		else $error("unmapped access not refused");
	idle_zero_a: assert property (
		!pready |-> !pslverr && (prdata == 32'h0000_0000))
		else $error("bus outputs not idle");
	irq_level_a: assert property (
		irq == |(irq_bus.status & $past(mask_r)))
		else $error("interrupt level wrong");
	cov_wide_c: cover property (wr_coarse && pwdata[B_WIDE] && pwdata[B_MULTI]);
	cov_fine_c: cover property (fine_en_w ##1 fine_loss);
	cov_irq_c: cover property ($rose(irq));
	cov_coarse_c: cover property (coarse_en_w ##1 coarse_loss);
	cov_multi_c: cover property (use_coarse_w && (phase_meas > ONE_UI));
endmodule

// *** tb/pdc_top_test.sv ***
// Self-checking testbench for the phase detector configuration block
`timescale 1ns/1ps
module pdc_top_test;
	import pdc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, no_activity;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, fine_loss, coarse_loss, phase_loss, wide_on, multi_on, irq;
	logic l1_auto, l2_auto;
	logic [2:0] l1_ana, l1_dig, l2_ana, l2_dig;
	logic [15:0] phase_offset;
	logic [BIAS_W-1:0] bias;
	pdc_phase_t phase_meas, loop_phase, tracked_phase;
	int fail_count = 0;
	int n_checks = 0;
	pdc_top pdc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phase_meas(phase_meas), .no_activity(no_activity),
		.loop_phase(loop_phase), .tracked_phase(tracked_phase), .fine_loss(fine_loss),
		.coarse_loss(coarse_loss), .phase_loss(phase_loss), .wide_detector_on(wide_on),
		.multi_cycle_response_enable(multi_on), .phase_offset(phase_offset),
		.buildout_bias_value(bias), .loop1_auto_gain_enable(l1_auto),
		.loop1_analog_gain_code(l1_ana), .loop1_digital_gain_code(l1_dig),
		.loop2_auto_gain_enable(l2_auto), .loop2_analog_gain_code(l2_ana),
		.loop2_digital_gain_code(l2_dig), .irq(irq));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 100) begin
			n++;
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) chk(32'h0, 32'h1, "pready timeout");
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, idx, {24'h000000, d}, rd, err);
		chk({31'h0, err}, 32'h0, "write error");
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
		logic [31:0] rd;
		logic err;
		apb(1'b0, idx, 32'h0, rd, err);
		chk(rd, exp, "read data");
		chk({31'h0, err}, {31'h0, experr}, "read error flag");
	endtask
	// Loss and clamp flops need one edge after a change; three leaves margin
	task automatic meas(input pdc_phase_t p);
		@(posedge pclk);
		phase_meas <= p;
		repeat (3) @(posedge pclk);
		#1;
	endtask
	task automatic t_defaults();
		rd_chk(IDX_GAIN2, 32'h000000C2, 1'b0);
		rd_chk(IDX_GAIN1, 32'h000000C2, 1'b0);
		rd_chk(IDX_OFS_HI, 32'h00000000, 1'b0);
		rd_chk(IDX_BIAS, 32'h00000000, 1'b0);
		rd_chk(IDX_FINE, 32'h000000A2, 1'b0);
		rd_chk(IDX_COARSE, 32'h00000085, 1'b0);
		rd_chk(8'hFF, 32'h00000000, 1'b1);
		chk({l1_auto, l1_ana, 1'b0, l1_dig}, 32'h000000C2, "loop1 gain fields");
		chk({l2_auto, l2_ana, 1'b0, l2_dig}, 32'h000000C2, "loop2 gain fields");
	endtask
	task automatic t_fields();
		wr(IDX_GAIN1, 8'h35);
		wr(IDX_OFS_LO, 8'h34);
		wr(IDX_OFS_HI, 8'hF2);
		wr(IDX_BIAS, 8'hFF);
		@(posedge pclk);
		#1;
		chk({l1_auto, l1_ana, 1'b0, l1_dig}, 32'h00000035, "loop1 gain write");
		chk({16'h0, phase_offset}, 32'h0000F234, "phase offset");
		chk({26'h0, bias}, 32'h0000003F, "buildout bias");
		rd_chk(IDX_OFS_LO, 32'h00000034, 1'b0);
	endtask
	task automatic t_fine();
		wr(IDX_COARSE, 8'h0C);
		wr(IDX_FINE, 8'h82);
		meas(24'sd384);
		chk({31'h0, fine_loss}, 32'h0, "fine window edge");
		meas(24'sd385);
		chk({31'h0, fine_loss}, 32'h1, "fine window exceeded");
		chk({31'h0, phase_loss}, 32'h1, "phase loss from fine");
		wr(IDX_FINE, 8'h02);
		meas(24'sd385);
		chk({31'h0, fine_loss}, 32'h0, "fine disabled");
		wr(IDX_FINE, 8'h40);
		no_activity <= 1'b1;
		meas(24'sd0);
		chk({31'h0, phase_loss}, 32'h1, "inactivity loss");
		rd_chk(IDX_STATE, 32'h00000009, 1'b0);
		wr(IDX_FINE, 8'h00);
		no_activity <= 1'b0;
	endtask
	task automatic t_coarse();
		wr(IDX_COARSE, 8'h81);
		meas(pdc_phase_t'(3 * 1024));
		chk({31'h0, coarse_loss}, 32'h0, "span code 1 inside");
		meas(pdc_phase_t'(-4 * 1024));
		chk({31'h0, coarse_loss}, 32'h1, "span code 1 outside");
		wr(IDX_COARSE, 8'h8C);
		meas(pdc_phase_t'(8191 * 1024));
		chk({31'h0, coarse_loss}, 32'h0, "span code 12 saturated");
		wr(IDX_COARSE, 8'h0B);
		meas(pdc_phase_t'(8191 * 1024));
		chk({31'h0, coarse_loss}, 32'h0, "coarse disabled");
	endtask
	task automatic t_clamp();
		wr(IDX_COARSE, 8'h05);
		meas(pdc_phase_t'(-5 * 1024));
		chk(loop_phase, -ONE_UI, "loop clamp one UI");
		chk(tracked_phase, -ONE_UI, "narrow tracking");
		wr(IDX_COARSE, 8'h45);
		meas(pdc_phase_t'(5 * 1024));
		chk({31'h0, wide_on}, 32'h1, "wide on");
		chk(tracked_phase, pdc_phase_t'(5 * 1024), "wide tracking");
		chk(loop_phase, ONE_UI, "wide without multi");
		wr(IDX_COARSE, 8'h25);
		meas(pdc_phase_t'(5 * 1024));
		chk(loop_phase, ONE_UI, "multi without wide");
		wr(IDX_COARSE, 8'h65);
		meas(pdc_phase_t'(70 * 1024));
		chk({31'h0, multi_on}, 32'h1, "multi on");
		chk(loop_phase, pdc_phase_t'(63 * 1024), "full coarse result");
		meas(pdc_phase_t'(5 * 1024));
		chk(loop_phase, pdc_phase_t'(5 * 1024), "unclamped result");
		wr(IDX_COARSE, 8'h0C);
	endtask
	task automatic t_irq();
		meas(24'sd0);
		wr(IDX_STATUS, 8'h07);
		wr(IDX_MASK, 8'h00);
		wr(IDX_FINE, 8'h80);
		meas(24'sd200);
		rd_chk(IDX_STATUS, 32'h00000001, 1'b0);
		chk({31'h0, irq}, 32'h0, "masked irq");
		wr(IDX_MASK, 8'h01);
		rd_chk(IDX_MASK, 32'h00000001, 1'b0);
		meas(24'sd200);
		chk({31'h0, irq}, 32'h1, "unmasked irq");
		wr(IDX_STATUS, 8'h01);
		meas(24'sd200);
		chk({31'h0, irq}, 32'h0, "irq after clear");
		rd_chk(IDX_STATUS, 32'h00000000, 1'b0);
	endtask
	// Reset in mid-run must drop written values back to defaults
	task automatic t_reset();
		wr(IDX_OFS_LO, 8'h5A);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(IDX_OFS_LO, 32'h00000000, 1'b0);
		rd_chk(IDX_COARSE, 32'h00000085, 1'b0);
		chk({16'h0, phase_offset}, 32'h00000000, "offset after reset");
		chk({31'h0, irq}, 32'h0, "irq after reset");
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		no_activity = 1'b0;
		phase_meas = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_fields();
		t_fine();
		t_coarse();
		t_clamp();
		t_irq();
		t_reset();
		conclude();
	end
	// Whole run is a few hundred cycles; this bound is generous
	initial begin
		#(25 * 20000);
		fail_count++;
		conclude();
	end
endmodule
